// [fts_pkg.sv]
package fts_pkg;

	// Register byte offsets
	localparam logic [7:0] AREA_SEL_OFS  = 8'h00;
	localparam logic [7:0] START_ADR_OFS = 8'h04;
	localparam logic [7:0] INIT_OFS      = 8'h08;
	localparam logic [7:0] STATUS_OFS    = 8'h0C;
	localparam logic [7:0] CLEAR_OFS     = 8'h10;
	localparam logic [7:0] ENABLE_OFS    = 8'h14;

	// Area select layout
	localparam int         KEY_MSB      = 15;
	localparam int         KEY_LSB      = 8;
	localparam int         BOOT_SEL_BIT = 1;
	localparam logic [7:0] AREA_KEY     = 8'h3B;
	localparam logic       BOOT_SEL_RST = 1'b0;

	// Start address reset and upper masks
	localparam logic [31:0] START_ADR_RST = 32'h0000_0000;
	localparam logic [31:0] CODE_MASK     = 32'h0FFF_FFFF;
	localparam logic [31:0] DATA_MASK     = 32'h001F_FFFF;
	localparam int          CHK_MSB       = 20;

	// Init register bit
	localparam int INIT_BIT = 0;

	// Event bits
	localparam int        EV_CODE_ERR  = 0;
	localparam int        EV_RANGE_ERR = 1;
	localparam int        EV_W         = 2;
	localparam logic [1:0] EV_RST      = 2'h0;

	// Alignment boundaries as log2 of bytes
	localparam logic [4:0] LG_4B   = 5'h02;
	localparam logic [4:0] LG_8B   = 5'h03;
	localparam logic [4:0] LG_32B  = 5'h05;
	localparam logic [4:0] LG_512B = 5'h09;
	localparam logic [4:0] LG_2K   = 5'h0B;
	localparam logic [4:0] LG_4K   = 5'h0C;
	localparam logic [4:0] LG_16K  = 5'h0E;
	localparam logic [4:0] LG_64K  = 5'h10;
	localparam logic [2:0] MULTI_MAX = 3'h4;

	typedef enum logic [3:0] {
		CMD_PROG       = 4'h0,
		CMD_MULTI      = 4'h1,
		CMD_DMA        = 4'h2,
		CMD_BLK_ERASE  = 4'h3,
		CMD_AREA_ERASE = 4'h4,
		CMD_BLANK      = 4'h5,
		CMD_PROP_PROG  = 4'h6,
		CMD_PROP_ERASE = 4'h7,
		CMD_SW_PROG    = 4'h8,
		CMD_SW_ERASE   = 4'h9,
		CMD_TAG_UPD    = 4'hA,
		CMD_TAG_ERASE  = 4'hB
	} fts_cmd_t;

	typedef enum logic [1:0] {
		REG_USER  = 2'h0,
		REG_BOOT  = 2'h1,
		REG_DATA  = 2'h2,
		REG_EXT   = 2'h3
	} fts_region_t;

endpackage : fts_pkg

// [fts_target_select.sv]
// Notes on behaviour
// - Area select picks legal code flash region
// - Boot select bit 1; one means boot
// - Key field not stored, reads zero
// - Area select writes change boot select only with key 3B
// - Boot select writable in serial/debug-break only
// - Area select and start address writes ignored while command busy, unless sequencer ready and lock state
// - Select zero: boot region target errors
// - Select one: user region target errors
// - Init bit resets both registers
// - Reserved area-select bits read zero
// - Start address holds command first address
// - Code flash ignores bits 31 to 28
// - Data flash ignores bits 31 to 21
// - Low bits below command boundary ignored
// - Multi program aligns to chosen size
// - Erase boundary depends on command, region
// - Bits 20 to 0 compared with end
// - Inconsistent start/end flags error, locks
`timescale 1ns/10ps

module fts_target_select (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Sequencer state
	input  wire logic        sequencer_ready_flag,
	input  wire logic        cmd_lock_state,
	input  wire logic        cmd_first_write,
	input  wire logic        serial_prog_mode,
	input  wire logic        debug_break,
	// Command issue
	input  wire logic        cmd_issue,
	input  wire logic [3:0]  cmd_code,
	input  wire logic [1:0]  cmd_region,
	input  wire logic [2:0]  multi_size,
	input  wire logic        block_64k,
	input  wire logic        blank_decrement,
	input  wire logic [31:0] command_end_address,
	// Command results
	output logic      [31:0] target_address,
	output logic             target_valid,
	output logic             code_access_error,
	output logic             range_error,
	output logic             cmd_lock_request,
	output logic             boot_area_sel,
	// Interrupt
	output logic             irq
);

	typedef struct packed {
		logic                      boot_sel;
		logic [31:0]               start_adr;
		logic                      busy;
		logic                      ready_prev;
		logic [fts_pkg::EV_W-1:0]  status;
		logic [fts_pkg::EV_W-1:0]  enable;
		logic [31:0]               rdata;
		logic [31:0]               tgt;
		logic                      tgt_vld;
		logic                      code_err;
		logic                      rng_err;
		logic                      lock_req;
	} fts_state_t;

	fts_state_t st_q;
	fts_state_t st_d;

	// Boundary for the command, as log2 of bytes
	function automatic logic [4:0] fts_bound(input logic [3:0] cmd, input logic [1:0] rgn,
		input logic [2:0] msz, input logic b64);
		logic       ext;
		logic [4:0] lg;
		ext = (rgn == fts_pkg::REG_EXT);
		lg  = fts_pkg::LG_4B;
		unique case (cmd)
			fts_pkg::CMD_PROG:
				lg = (rgn == fts_pkg::REG_DATA || ext) ? fts_pkg::LG_4B : fts_pkg::LG_512B;
			fts_pkg::CMD_MULTI:
				lg = fts_pkg::LG_8B + 5'((msz > fts_pkg::MULTI_MAX) ? fts_pkg::MULTI_MAX : msz);
			fts_pkg::CMD_DMA,
			fts_pkg::CMD_BLANK,
			fts_pkg::CMD_TAG_UPD:
				lg = fts_pkg::LG_4B;
			fts_pkg::CMD_BLK_ERASE: begin
				if (rgn == fts_pkg::REG_DATA) begin
					lg = fts_pkg::LG_4K;
				end else if (ext) begin
					lg = fts_pkg::LG_2K;
				end else begin
					lg = b64 ? fts_pkg::LG_64K : fts_pkg::LG_16K;
				end
			end
			fts_pkg::CMD_AREA_ERASE:
				lg = ext ? fts_pkg::LG_2K : fts_pkg::LG_4K;
			fts_pkg::CMD_PROP_PROG,
			fts_pkg::CMD_SW_PROG:
				lg = fts_pkg::LG_32B;
			fts_pkg::CMD_PROP_ERASE,
			fts_pkg::CMD_SW_ERASE,
			fts_pkg::CMD_TAG_ERASE:
				lg = fts_pkg::LG_2K;
			default:
				lg = fts_pkg::LG_4B;
		endcase
		return lg;
	endfunction : fts_bound

	// Mask with ones above the boundary
	function automatic logic [31:0] fts_align(input logic [4:0] lg);
		return 32'hFFFF_FFFF << lg;
	endfunction : fts_align

	logic        wr_area;
	logic        wr_start;
	logic        wr_init;
	logic        wr_clear;
	logic        wr_enable;
	logic        locked;
	logic        code_rgn;
	logic [31:0] up_mask;
	logic [31:0] tgt_adr;
	logic        sel_err;
	logic        chk_cmd;
	logic        inconsistent;

	localparam int CHK_W = fts_pkg::CHK_MSB + 1;

	logic [CHK_W-1:0] s_low;
	logic [CHK_W-1:0] e_low;
	logic [fts_pkg::EV_W-1:0] ev_set;

	assign wr_area   = reg_wr && reg_addr == fts_pkg::AREA_SEL_OFS;
	assign wr_start  = reg_wr && reg_addr == fts_pkg::START_ADR_OFS;
	assign wr_init   = reg_wr && reg_addr == fts_pkg::INIT_OFS && reg_wdata[fts_pkg::INIT_BIT];
	assign wr_clear  = reg_wr && reg_addr == fts_pkg::CLEAR_OFS;
	assign wr_enable = reg_wr && reg_addr == fts_pkg::ENABLE_OFS;

	// Busy from first command write until ready rises, unless locked and ready
	assign locked = st_q.busy && !(sequencer_ready_flag && cmd_lock_state);

	assign code_rgn = cmd_region == fts_pkg::REG_USER || cmd_region == fts_pkg::REG_BOOT;
	assign up_mask  = code_rgn ? fts_pkg::CODE_MASK : fts_pkg::DATA_MASK;
	assign tgt_adr  = st_q.start_adr & up_mask
		& fts_align(fts_bound(cmd_code, cmd_region, multi_size, block_64k));

	// Only the unselected code region is refused
	assign sel_err = (cmd_region == fts_pkg::REG_BOOT && !st_q.boot_sel)
		|| (cmd_region == fts_pkg::REG_USER && st_q.boot_sel);

	assign s_low   = st_q.start_adr[fts_pkg::CHK_MSB:0];
	assign e_low   = command_end_address[fts_pkg::CHK_MSB:0];
	assign chk_cmd = cmd_code == fts_pkg::CMD_AREA_ERASE || cmd_code == fts_pkg::CMD_BLANK;
	assign inconsistent = chk_cmd && ((cmd_code == fts_pkg::CMD_BLANK && blank_decrement)
		? (s_low < e_low) : (s_low > e_low));

	assign ev_set[fts_pkg::EV_CODE_ERR]  = cmd_issue && code_rgn && sel_err;
	assign ev_set[fts_pkg::EV_RANGE_ERR] = cmd_issue && inconsistent;

	always_comb begin
		st_d = st_q;

		st_d.ready_prev = sequencer_ready_flag;
		if (cmd_first_write) begin
			st_d.busy = 1'b1;
		end else if (sequencer_ready_flag && !st_q.ready_prev) begin
			st_d.busy = 1'b0;
		end

		// Key check and bit update in the same access
		if (wr_area && !locked && (serial_prog_mode || debug_break)
			&& reg_wdata[fts_pkg::KEY_MSB:fts_pkg::KEY_LSB] == fts_pkg::AREA_KEY) begin
			st_d.boot_sel = reg_wdata[fts_pkg::BOOT_SEL_BIT];
		end

		if (wr_start && !locked) begin
			st_d.start_adr = reg_wdata;
		end

		if (wr_enable) begin
			st_d.enable = reg_wdata[fts_pkg::EV_W-1:0];
		end

		// Event set wins over a clear in the same cycle
		st_d.status = (st_q.status & ~(wr_clear ? reg_wdata[fts_pkg::EV_W-1:0] : '0)) | ev_set;

		st_d.tgt_vld  = cmd_issue && !ev_set[fts_pkg::EV_CODE_ERR] && !inconsistent;
		st_d.code_err = ev_set[fts_pkg::EV_CODE_ERR];
		st_d.rng_err  = ev_set[fts_pkg::EV_RANGE_ERR];
		st_d.lock_req = ev_set[fts_pkg::EV_RANGE_ERR];
		if (cmd_issue) begin
			st_d.tgt = tgt_adr;
		end

		st_d.rdata = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				fts_pkg::AREA_SEL_OFS:
					st_d.rdata[fts_pkg::BOOT_SEL_BIT] = st_q.boot_sel;
				fts_pkg::START_ADR_OFS:
					st_d.rdata = st_q.start_adr;
				fts_pkg::STATUS_OFS:
					st_d.rdata[fts_pkg::EV_W-1:0] = st_q.status;
				fts_pkg::ENABLE_OFS:
					st_d.rdata[fts_pkg::EV_W-1:0] = st_q.enable;
				default:
					st_d.rdata = 32'h0000_0000;
			endcase
		end

		if (wr_init) begin
			st_d.boot_sel  = fts_pkg::BOOT_SEL_RST;
			st_d.start_adr = fts_pkg::START_ADR_RST;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_q            <= '0;
			st_q.boot_sel   <= fts_pkg::BOOT_SEL_RST;
			st_q.start_adr  <= fts_pkg::START_ADR_RST;
			st_q.status     <= fts_pkg::EV_RST;
			st_q.enable     <= fts_pkg::EV_RST;
			st_q.ready_prev <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata         = st_q.rdata;
	assign target_address    = st_q.tgt;
	assign target_valid      = st_q.tgt_vld;
	assign code_access_error = st_q.code_err;
	assign range_error       = st_q.rng_err;
	assign cmd_lock_request  = st_q.lock_req;
	assign boot_area_sel     = st_q.boot_sel;
	assign irq               = |(st_q.status & st_q.enable);

endmodule : fts_target_select

// [fts_target_select_monitor.sv]
`timescale 1ns/10ps

module fts_target_select_monitor (
	// Watched ports
	input wire logic        clk, srst, reg_wr, reg_rd, sequencer_ready_flag, cmd_lock_state,
	input wire logic        serial_prog_mode, debug_break, cmd_issue, target_valid, code_access_error,
	input wire logic        range_error, cmd_lock_request, boot_area_sel,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata, reg_rdata, target_address,
	input wire logic [1:0]  cmd_region
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	wire area_wr  = reg_wr && reg_addr == fts_pkg::AREA_SEL_OFS;
	wire key_ok   = reg_wdata[15:8] == fts_pkg::AREA_KEY;
	wire mode_ok  = serial_prog_mode || debug_break;
	wire boot_bit = reg_wdata[fts_pkg::BOOT_SEL_BIT];

	area_rd_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00 |->
		reg_rdata == {30'h0, $past(boot_area_sel), 1'b0}) else $error("area select read wrong");
	bad_key_a: assert property (area_wr && !key_ok |=> $stable(boot_area_sel))
		else $error("boot select changed without key");
	no_mode_a: assert property (area_wr && !mode_ok |=> $stable(boot_area_sel))
		else $error("boot select changed outside mode");
	key_upd_a: assert property (area_wr && key_ok && mode_ok && sequencer_ready_flag && cmd_lock_state
		|=> boot_area_sel == $past(boot_bit)) else $error("boot select not updated");
	init_clr_a: assert property (reg_wr && reg_addr == 8'h08 && reg_wdata[0] |=> !boot_area_sel)
		else $error("init did not clear boot select");
	user_err_a: assert property (cmd_issue && cmd_region == 2'h0 && boot_area_sel
		|=> code_access_error && !target_valid) else $error("user region not refused");
	boot_err_a: assert property (cmd_issue && cmd_region == 2'h1 && !boot_area_sel
		|=> code_access_error && !target_valid) else $error("boot region not refused");
	lock_req_a: assert property (range_error |-> cmd_lock_request && !target_valid)
		else $error("range error without lock");
	code_msk_a: assert property (target_valid |-> target_address[31:28] == 4'h0)
		else $error("code mask wrong");
	data_msk_a: assert property (target_valid && $past(cmd_region) >= 2'h2 |-> target_address[31:21] == 11'h0)
		else $error("data mask wrong");
endmodule : fts_target_select_monitor

// [testbench.sv]
`timescale 1ns/10ps

module testbench;
	logic        clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, sequencer_ready_flag = 1, cmd_lock_state = 1;
	logic        cmd_first_write = 0, serial_prog_mode = 0, debug_break = 0, cmd_issue = 0, block_64k = 0;
	logic        blank_decrement = 0, target_valid, code_access_error, range_error, cmd_lock_request;
	logic        boot_area_sel, irq;
	logic [7:0]  reg_addr = '0;
	logic [31:0] reg_wdata = '0, reg_rdata, command_end_address = '0, target_address;
	logic [3:0]  cmd_code = '0;
	logic [1:0]  cmd_region = '0;
	logic [2:0]  multi_size = '0;
	int          miscompares = 0, cmp_count = 0;

	fts_target_select u_dut (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.sequencer_ready_flag, .cmd_lock_state, .cmd_first_write, .serial_prog_mode, .debug_break,
		.cmd_issue, .cmd_code, .cmd_region, .multi_size, .block_64k, .blank_decrement,
		.command_end_address, .target_address, .target_valid, .code_access_error, .range_error,
		.cmd_lock_request, .boot_area_sel, .irq);

	always #10 clk = ~clk;

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data lives only in the cycle after the strobe
	task automatic rd(logic [7:0] a, logic [31:0] e);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk("rdata", e, reg_rdata);
	endtask : rd

	// Flags are {valid, code error, range error}; address only meaningful when valid
	task automatic cmd(logic [3:0] c, logic [1:0] r, logic [2:0] s, logic [31:0] e, logic [2:0] f);
		@(posedge clk);
		cmd_issue  <= 1'b1;
		cmd_code   <= c;
		cmd_region <= r;
		multi_size <= s;
		@(posedge clk);
		cmd_issue <= 1'b0;
		#1 chk("flags", {29'h0, f}, {29'h0, target_valid, code_access_error, range_error});
		if (f[2]) chk("target", e, target_address);
	endtask : cmd

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : stop_test

	initial begin
		#100us;
		miscompares++;
		stop_test;
	end

	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h20, 32'h0);
		wr(8'h00, 32'h0000_3B02);
		rd(8'h00, 32'h0);
		@(posedge clk) debug_break <= 1'b1;
		wr(8'h00, 32'h0000_3C02);
		rd(8'h00, 32'h0);
		wr(8'h00, 32'h0000_3B02);
		rd(8'h00, 32'h0000_0002);
		$display("area select test done");
		wr(8'h14, 32'h1);
		wr(8'h04, 32'hFFFF_FFFF);
		cmd(4'h0, 2'h0, 3'h0, 32'h0, 3'b010);
		rd(8'h0C, 32'h1);
		chk("irq", 32'h1, {31'h0, irq});
		wr(8'h10, 32'h1);
		@(posedge clk);
		#1 chk("irq", 32'h0, {31'h0, irq});
		cmd(4'h0, 2'h1, 3'h0, 32'h0FFF_FE00, 3'b100);
		wr(8'h08, 32'h1);
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		cmd(4'h0, 2'h1, 3'h0, 32'h0, 3'b010);
		wr(8'h04, 32'h1234_5677);
		cmd(4'h0, 2'h2, 3'h0, 32'h0014_5674, 3'b100);
		$display("error and mask test done");
		wr(8'h04, 32'hFFFF_FFFF);
		for (int i = 0; i < 5; i++) begin
			cmd(4'h1, 2'h2, i[2:0], 32'h001F_FFFF & ~((32'h8 << i) - 32'h1), 3'b100);
		end
		cmd(4'h1, 2'h3, 3'h7, 32'h001F_FF80, 3'b100);
		cmd(4'h2, 2'h0, 3'h0, 32'h0FFF_FFFC, 3'b100);
		cmd(4'h3, 2'h3, 3'h0, 32'h001F_F800, 3'b100);
		cmd(4'h3, 2'h2, 3'h0, 32'h001F_F000, 3'b100);
		cmd(4'h3, 2'h0, 3'h0, 32'h0FFF_C000, 3'b100);
		@(posedge clk) block_64k <= 1'b1;
		cmd(4'h3, 2'h0, 3'h0, 32'h0FFF_0000, 3'b100);
		cmd(4'h4, 2'h2, 3'h0, 32'h0, 3'b001);
		@(posedge clk) command_end_address <= 32'h001F_FFFF;
		cmd(4'h4, 2'h3, 3'h0, 32'h001F_F800, 3'b100);
		cmd(4'h5, 2'h2, 3'h0, 32'h001F_FFFC, 3'b100);
		@(posedge clk) blank_decrement <= 1'b1;
		cmd(4'h5, 2'h2, 3'h0, 32'h001F_FFFC, 3'b100);
		@(posedge clk) command_end_address <= 32'h0000_0000;
		cmd(4'h5, 2'h3, 3'h0, 32'h001F_FFFC, 3'b100);
		for (int c = 6; c < 12; c++) begin
			cmd(c[3:0], 2'h0, 3'h0,
				c[0] ? 32'h0FFF_F800 : (c == 10 ? 32'h0FFF_FFFC : 32'h0FFF_FFE0), 3'b100);
		end
		$display("alignment test done");
		@(posedge clk) cmd_lock_state <= 1'b0;
		cmd_first_write <= 1'b1;
		@(posedge clk) cmd_first_write <= 1'b0;
		wr(8'h04, 32'h0000_0100);
		wr(8'h00, 32'h0000_3B02);
		rd(8'h04, 32'hFFFF_FFFF);
		rd(8'h00, 32'h0);
		@(posedge clk) sequencer_ready_flag <= 1'b0;
		@(posedge clk) sequencer_ready_flag <= 1'b1;
		repeat (2) @(posedge clk);
		wr(8'h04, 32'h0000_0100);
		rd(8'h04, 32'h0000_0100);
		$display("busy test done");
		stop_test;
	end
endmodule : testbench

bind fts_target_select fts_target_select_monitor u_mon (.clk, .srst, .reg_wr, .reg_rd, .sequencer_ready_flag,
	.cmd_lock_state, .serial_prog_mode, .debug_break, .cmd_issue, .target_valid, .code_access_error,
	.range_error, .cmd_lock_request, .boot_area_sel, .reg_addr, .reg_wdata, .reg_rdata, .target_address,
	.cmd_region);
